// ---- asfr_core_model.sv ----
// core-side model: drives requests, notes expected results
`timescale 1ns/1ns
`default_nettype none
module asfr_core_model
   import asfr_pkg::*;
(
   input  wire logic         clk, // core clock
   output var  asfr_req_type req  // request toward flag block
);
   logic [FLAG_W-1:0] f = FLAGS_RST; // expected n ov z dc c
   logic [9:0]        exp_q[$];      // {dest status, no-op, data}
   logic [FLAG_W-1:0] fexp_q[$];     // expected flags per request
   initial req = '0;
   ////////////////////////////////////////
   // one request per edge; calls in a row go back to back
   task automatic send(input asfr_op_type op, input logic [7:0] a, b,
                       input logic [2:0] bs, input logic ds);
      logic [8:0] s;
      logic [4:0] nb;
      logic [7:0] bb;
      logic [7:0] r;
      logic       ci;
      ci = (op == ASFR_OP_SUB);
      bb = ci ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
      nb = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
      r = 8'h00;
      case (op)
         ASFR_OP_ADD, ASFR_OP_SUB: begin
            r = s[7:0];
            f = {r[7], a[7] == bb[7] && r[7] != a[7], r == 8'h00, nb[4], s[8]};
         end
         ASFR_OP_LOGIC: begin
            r = a & b;
            f[4] = r[7];
            f[2] = (r == 8'h00);
         end
         ASFR_OP_CLEAR: f[2] = 1'b1;
         ASFR_OP_BIT_CLEAR: r = a & ~(8'h01 << bs);
         ASFR_OP_BIT_SET: r = a | (8'h01 << bs);
         ASFR_OP_SWAP: r = {a[3:0], a[7:4]};
         ASFR_OP_MOVE_FF, ASFR_OP_MOVE_WF: r = b;
         default: r = 8'h00; // no-op: nothing changes
      endcase
      if (ds && op > ASFR_OP_CLEAR) f = r[4:0];
      exp_q.push_back({ds, op == ASFR_OP_NONE, r});
      fexp_q.push_back(f);
      @(posedge clk);
      req <= '{valid: 1'b1, op: op, opnd_a: a, opnd_b: b, bit_sel: bs,
               dest_status: ds};
   endtask
   // drop the request line after a burst
   task automatic idle();
      @(posedge clk);
      req.valid <= 1'b0;
   endtask
endmodule // asfr_core_model
`default_nettype wire

// ---- asfr_flags.sv ----
// arithmetic status flag register with its alu flag logic
`timescale 1ns/1ns
`default_nettype none
module asfr_flags
   import asfr_pkg::*;
(
   input  wire logic              clk,         // core clock, 125 mhz
   input  wire logic              rst,         // synchronous reset, high
   input  wire asfr_req_type      req,         // instruction request
   output var  asfr_res_type      res,         // result toward the core
   output var  logic [DATA_W-1:0] status_rd    // status read view
);

   asfr_state_type s_q;                        // registered state
   asfr_state_type s_d;                        // next state

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [DATA_W:0]   sum;                  // 9-bit sum with carry out
      logic [NIB_W:0]    nsum;                 // nibble sum with carry out
      logic [DATA_W-1:0] bop;                  // effective second operand
      logic [DATA_W-1:0] r;                    // computed result
      logic [FLAG_W-1:0] f;                    // new flags
      logic              arith;                // add or subtract
      logic              logic_op;             // logic class
      sum      = '0;
      nsum     = '0;
      bop      = req.opnd_b;
      r        = BYTE_ZERO;
      f        = s_q.flags;
      arith    = 1'b0;
      logic_op = 1'b0;
      s_d      = s_q;
      s_d.res  = '0;
      // subtract adds the inverted operand plus one
      if (req.op == ASFR_OP_SUB) begin
         bop = ~req.opnd_b;                    // RULE9
      end
      // a status operand is read by the core from status_rd and arrives
      // on opnd_a or opnd_b, so no special path is needed here; the
      // trade is one cycle between a flag change and its use as data
      case (req.op)
         ASFR_OP_ADD, ASFR_OP_SUB: begin
            arith = 1'b1;
            sum   = {1'b0, req.opnd_a} + {1'b0, bop}
                  + {{DATA_W{1'b0}}, (req.op == ASFR_OP_SUB)};
            nsum  = {1'b0, req.opnd_a[NIB_W-1:0]} + {1'b0, bop[NIB_W-1:0]}
                  + {{NIB_W{1'b0}}, (req.op == ASFR_OP_SUB)};
            r     = sum[DATA_W-1:0];
         end
         ASFR_OP_LOGIC: begin
            logic_op = 1'b1;
            r        = req.opnd_a & req.opnd_b;
         end
         ASFR_OP_CLEAR:     r = BYTE_ZERO;
         ASFR_OP_BIT_CLEAR: r = req.opnd_a & ~(8'h01 << req.bit_sel);
         ASFR_OP_BIT_SET:   r = req.opnd_a | (8'h01 << req.bit_sel);
         ASFR_OP_SWAP:      r = {req.opnd_a[NIB_W-1:0],
                                 req.opnd_a[DATA_W-1:NIB_W]};
         ASFR_OP_MOVE_FF, ASFR_OP_MOVE_WF: r = req.opnd_b;
         default:           r = BYTE_ZERO;
      endcase
      // flag update; bit ops, swap and moves change none
      if (arith) begin
         f[BIT_CARRY]    = sum[DATA_W];           // RULE5 RULE9
         f[BIT_NIBBLE]   = nsum[NIB_W];           // RULE8 RULE5
         f[BIT_RANGE]    = (req.opnd_a[DATA_W-1] == bop[DATA_W-1]) &&
                           (r[DATA_W-1] != req.opnd_a[DATA_W-1]); // RULE7
      end
      if (arith || logic_op || req.op == ASFR_OP_CLEAR) begin
         f[BIT_ZERO]     = (r == BYTE_ZERO);
         f[BIT_NEGATIVE] = r[DATA_W-1];           // RULE6
      end
      if (req.op == ASFR_OP_CLEAR) begin
         f = s_q.flags;
         f[BIT_ZERO] = 1'b1;                      // RULE3
      end
      if (req.valid) begin
         s_d.res.valid = 1'b1;
         s_d.res.data  = r;
         s_d.res.write = !req.dest_status;
         if (arith || logic_op || req.op == ASFR_OP_CLEAR) begin
            // result dropped when status is destination
            s_d.flags = f;                        // RULE2 RULE3
         end else if (req.dest_status && req.op != ASFR_OP_NONE) begin
            s_d.flags = r[FLAG_W-1:0];            // RULE1 RULE4
         end
      end
      // flags not written above hold their value through s_d = s_q
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '{flags: FLAGS_RST, res: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs come straight from the state register, no logic after it
   assign res       = s_q.res;
   assign status_rd = {3'h0, s_q.flags};          // RULE3

   ////////////////////////////////////////////////////////////////////////
   // checks: each but chk_result_idle looks one cycle after a request is taken, when the
   // registered flags and result show that request; expectations are
   // rebuilt from the sampled operands, though the negative, overflow and zero checks read the registered res.data

   // request classes shared by the properties below
   sequence s_take_add;                           // add taken
      req.valid && req.op == ASFR_OP_ADD;
   endsequence
   sequence s_take_sub;                           // subtract taken
      req.valid && req.op == ASFR_OP_SUB;
   endsequence
   sequence s_take_clear;                         // clear_file taken
      req.valid && req.op == ASFR_OP_CLEAR;
   endsequence
   sequence s_take_quiet;                         // flag-neutral op taken
      req.valid && req.op inside {ASFR_OP_BIT_CLEAR, ASFR_OP_BIT_SET,
                                  ASFR_OP_SWAP, ASFR_OP_MOVE_FF,
                                  ASFR_OP_MOVE_WF};
   endsequence

   // answer timing: one result pulse per request, none otherwise
   chk_result_pulse: assert property (@(posedge clk) // RULE1
      disable iff (rst)
      req.valid |=> res.valid)
      else $error("result pulse missing");
   chk_result_idle: assert property (@(posedge clk) // RULE1
      disable iff (rst)
      !req.valid |=> !res.valid)
      else $error("result without request");

   // clear of status: zero set, the other four flags kept
   chk_clear_sets_zero: assert property (@(posedge clk) // RULE3
      disable iff (rst)
      s_take_clear ##0 req.dest_status
      |=> status_rd[BIT_ZERO] &&
          status_rd[BIT_CARRY] == $past(status_rd[BIT_CARRY]) &&
          status_rd[BIT_NIBBLE] == $past(status_rd[BIT_NIBBLE]) &&
          status_rd[BIT_RANGE] == $past(status_rd[BIT_RANGE]) &&
          status_rd[BIT_NEGATIVE] == $past(status_rd[BIT_NEGATIVE]))
      else $error("clear of status wrong");

   // a write aimed at status keeps its result off the data path
   chk_drop_result: assert property (@(posedge clk) // RULE2
      disable iff (rst)
      req.valid && req.dest_status |=> !res.write)
      else $error("result not dropped");

   // bit ops, swap and moves not aimed at status leave the flags alone
   chk_moves_keep: assert property (@(posedge clk) // RULE4
      disable iff (rst)
      s_take_quiet ##0 !req.dest_status |=> $stable(status_rd))
      else $error("flags changed by move");

   // sign, carry, digit carry and overflow of an add
   chk_negative: assert property (@(posedge clk) // RULE6
      disable iff (rst)
      s_take_add ##0 !req.dest_status
      |=> status_rd[BIT_NEGATIVE] == res.data[DATA_W-1])
      else $error("negative flag wrong");
   chk_add_carry: assert property (@(posedge clk) // RULE9
      disable iff (rst)
      s_take_add
      |=> status_rd[BIT_CARRY] == (({1'b0, $past(req.opnd_a)}
          + {1'b0, $past(req.opnd_b)}) > 9'h0ff))
      else $error("add carry wrong");
   chk_nibble: assert property (@(posedge clk) // RULE8
      disable iff (rst)
      s_take_add
      |=> status_rd[BIT_NIBBLE] == ((5'($past(req.opnd_a[NIB_W-1:0]))
          + 5'($past(req.opnd_b[NIB_W-1:0]))) > 5'h0f))
      else $error("nibble carry wrong");
   chk_overflow: assert property (@(posedge clk) // RULE7
      disable iff (rst)
      s_take_add ##0 !req.dest_status
      |=> status_rd[BIT_RANGE] == ($past(req.opnd_a[DATA_W-1]) ==
          $past(req.opnd_b[DATA_W-1]) &&
          res.data[DATA_W-1] != $past(req.opnd_a[DATA_W-1])))
      else $error("overflow flag wrong");

   // subtract: zero flag, then carry and digit carry read as not-borrow
   chk_zero_flag: assert property (@(posedge clk) // RULE9
      disable iff (rst)
      s_take_sub ##0 !req.dest_status
      |=> status_rd[BIT_ZERO] == (res.data == BYTE_ZERO))
      else $error("zero flag wrong");
   chk_sub_borrow: assert property (@(posedge clk) // RULE5
      disable iff (rst)
      s_take_sub
      |=> status_rd[BIT_CARRY] == ($past(req.opnd_a) >= $past(req.opnd_b)))
      else $error("borrow polarity wrong");
   chk_sub_digit: assert property (@(posedge clk) // RULE5
      disable iff (rst)
      s_take_sub
      |=> status_rd[BIT_NIBBLE] == ($past(req.opnd_a[NIB_W-1:0]) >=
          $past(req.opnd_b[NIB_W-1:0])))
      else $error("digit borrow wrong");

   // logic class touches only zero and negative
   chk_logic_flags: assert property (@(posedge clk) // RULE6
      disable iff (rst)
      req.valid && req.op == ASFR_OP_LOGIC
      |=> status_rd[BIT_ZERO] ==
          (($past(req.opnd_a) & $past(req.opnd_b)) == BYTE_ZERO) &&
          status_rd[BIT_NEGATIVE] ==
          ($past(req.opnd_a[DATA_W-1]) & $past(req.opnd_b[DATA_W-1])) &&
          status_rd[BIT_CARRY] == $past(status_rd[BIT_CARRY]))
      else $error("logic flags wrong");

   // status as a plain destination: low five result bits land in it
   chk_status_write: assert property (@(posedge clk) // RULE1
      disable iff (rst)
      req.valid && req.op == ASFR_OP_MOVE_WF && req.dest_status
      |=> status_rd == {3'h0, $past(req.opnd_b[FLAG_W-1:0])})
      else $error("status write lost");
   chk_move_ff_write: assert property (@(posedge clk) // RULE1
      disable iff (rst)
      req.valid && req.op == ASFR_OP_MOVE_FF && req.dest_status
      |=> status_rd[FLAG_W-1:0] == $past(req.opnd_b[FLAG_W-1:0]))
      else $error("status move lost");
   chk_swap_write: assert property (@(posedge clk) // RULE1
      disable iff (rst)
      req.valid && req.op == ASFR_OP_SWAP && req.dest_status
      |=> status_rd[FLAG_W-1:0] == {$past(req.opnd_a[0]),
          $past(req.opnd_a[DATA_W-1:NIB_W])})
      else $error("status swap lost");
endmodule // asfr_flags
`default_nettype wire

// ---- asfr_flags_test.sv ----
// self-checking bench for the status flag register
`timescale 1ns/1ns
`default_nettype none
module asfr_flags_test;
   import asfr_pkg::*;
   logic              clk = 1'b0; // 125 mhz core clock
   logic              rst = 1'b1; // held for 8 cycles
   asfr_req_type      req;        // from core model
   asfr_res_type      res;        // result out
   logic [DATA_W-1:0] status_rd;  // status view
   int                num_errors = 0;
   int                num_checks = 0;
   always #4 clk = ~clk;
   asfr_flags i_dut (.clk(clk), .rst(rst), .req(req), .res(res),
                     .status_rd(status_rd));
   asfr_core_model i_core (.clk(clk), .req(req));
   ////////////////////////////////////////
   // a mismatch with nothing to compare: count and print it
   task automatic fail_one(input string what);
      num_errors++;
      $display("ERROR %0t %s", $time, what);
   endtask
   // compare the status view against the expected flags
   task automatic check_flags(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t flags got %h exp %h", $time, got, exp);
      end
   endtask
   // compare the result byte
   task automatic check_data(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t data got %h exp %h", $time, got, exp);
      end
   endtask
   // compare the store qualifier
   task automatic check_write(input logic got, exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t write got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watcher: sample mid-cycle, once outputs have settled
   always @(negedge clk) begin
      logic [9:0] e;
      if (res.valid === 1'b1 && i_core.exp_q.size() == 0)
         fail_one("unexpected result");
      else if (res.valid === 1'b1) begin
         e = i_core.exp_q.pop_front();
         check_flags(status_rd, {3'h0, i_core.fexp_q.pop_front()});
         if (!e[9]) check_data(res.data, e[7:0]);
         if (!e[8]) check_write(res.write, !e[9]);
      end
   end
   ////////////////////////////////////////
   // main sequence: directed corners, then random back-to-back traffic
   initial begin
      int seed;
      seed = $urandom(3);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check_flags(status_rd, {3'h0, FLAGS_RST});
      i_core.send(ASFR_OP_ADD, 8'h7f, 8'h01, 3'h0, 1'b0);
      i_core.send(ASFR_OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0);
      i_core.send(ASFR_OP_CLEAR, 8'h00, 8'h00, 3'h0, 1'b1);
      i_core.send(ASFR_OP_ADD, {3'h0, i_core.f}, 8'h01, 3'h0, 1'b1);
      for (int i = 0; i < 400; i++)
         i_core.send(asfr_op_type'($urandom_range(9)), 8'($urandom),
                     8'($urandom), 3'($urandom), $urandom_range(3) == 0);
      i_core.idle();
      for (int i = 0; i < 10 && i_core.exp_q.size() != 0; i++)
         @(posedge clk);
      if (i_core.exp_q.size() != 0)
         fail_one("missing results");
      report_and_stop();
   end
endmodule // asfr_flags_test
`default_nettype wire

// ---- asfr_pkg.sv ----
// constants and types for the arithmetic status flag register
//
// Summary of operation
// [RULE1] status register is an ordinary read/write operand
// [RULE2] flag-affecting write to status drops result
// [RULE3] clear of status sets zero flag only
// [RULE4] bit ops, swap, moves leave flags alone
// [RULE5] carry and nibble carry mean borrow when subtracting; the code sets them on no borrow (a >= b)
// [RULE6] negative flag follows result most significant bit
// [RULE7] overflow set when signed sign bit flips
// [RULE8] nibble carry from the fourth low bit
// [RULE9] subtract adds two's complement, borrow inverted
package asfr_pkg;
   localparam int unsigned DATA_W   = 8;     // byte width of the core
   localparam int unsigned FLAG_W   = 5;     // implemented flag bits
   localparam int unsigned NIB_W    = 4;     // low nibble width
   localparam int unsigned BIT_CARRY    = 0; // flag positions
   localparam int unsigned BIT_NIBBLE   = 1;
   localparam int unsigned BIT_ZERO     = 2;
   localparam int unsigned BIT_RANGE    = 3;
   localparam int unsigned BIT_NEGATIVE = 4;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00; // reset value of flags
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00; // all-zero byte

   // operation codes from the execution logic
   typedef enum logic [3:0] {
      ASFR_OP_NONE,       // no operation this cycle
      ASFR_OP_ADD,        // add, all five flags
      ASFR_OP_SUB,        // subtract a minus b, all five flags
      ASFR_OP_LOGIC,      // logic and of a and b, zero and negative only
      ASFR_OP_CLEAR,      // clear_file
      ASFR_OP_BIT_CLEAR,  // bit_clear_file
      ASFR_OP_BIT_SET,    // bit_set_file
      ASFR_OP_SWAP,       // nibble_swap_file
      ASFR_OP_MOVE_FF,    // move_file_to_file
      ASFR_OP_MOVE_WF     // move_working_to_file
   } asfr_op_type;

   // one instruction request from the core
   typedef struct packed {
      logic              valid;      // request present
      asfr_op_type       op;         // what to do
      logic [DATA_W-1:0] opnd_a;     // first operand
      logic [DATA_W-1:0] opnd_b;     // second operand or move data
      logic [2:0]        bit_sel;    // bit index for bit ops
      logic              dest_status; // destination is status register
   } asfr_req_type;

   // result toward the core
   typedef struct packed {
      logic              valid;      // result present
      logic              write;      // result should be stored
      logic [DATA_W-1:0] data;       // computed result
   } asfr_res_type;

   // whole block state
   typedef struct packed {
      logic [FLAG_W-1:0] flags;      // n, ov, z, dc, c
      asfr_res_type      res;        // registered result
   } asfr_state_type;
endpackage : asfr_pkg
